// ==== design/rail_enable_sequencer.sv ====
`timescale 1ns/1ns
`default_nettype none
module rail_enable_sequencer #(
	parameter int unsigned PD_DELAY_CYCLES = rail_seq_pkg::PD_DELAY_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        enable_pin_one_i,
	input  wire logic        enable_pin_two_i,
	input  wire logic        enable_pin_four_i,
	input  wire logic        enable_pin_five_i,
	input  wire logic [5:0]  buck_pg_i,
	output logic      [5:0]  buck_en_o,
	output logic      [5:0]  buck_pwm_o,
	output logic      [41:0] buck_vid_o,
	output logic      [5:0]  buck_fine_range_o,
	output logic      [5:0]  buck_disch_on_o,
	output logic      [11:0] disch_strength_o,
	output logic             vtt_en_o,
	output logic             switch_a_first_en_o,
	output logic             switch_b_first_en_o,
	output logic             switch_b_second_en_o,
	output logic             first_aux_ldo_en_o,
	output logic             second_aux_ldo_en_o,
	output logic             third_aux_ldo_en_o,
	output logic             pg_out_one_o,
	output logic             pg_out_one_oe_o,
	output logic             pg_out_two_o,
	output logic             pg_out_two_oe_o,
	output logic             gpo_three_o,
	output logic             gpo_three_oe_o,
	output logic             gpo_four_o,
	output logic             gpo_four_oe_o
);
	// Per-rail control: mode and target code
	logic [8:0]  ctrl_q [6];
	logic [31:0] disch_q [3];   // Discharge control words
	logic [3:0]  shared_q;      // Enable and discharge of LDO or switch
	logic [1:0]  aux_q;         // Software enables for aux LDOs
	logic [1:0]  gpo_q;         // Software levels for unmapped outputs
	logic [5:0]  en_q;          // Registered rail enables
	logic        pg_one_q;      // Internal power-good level, first group
	logic        pg_two_q;      // Internal power-good level, system
	logic [31:0] cnt_q [6];     // Power-down delay counters
	logic [5:0]  cond;          // Raw enable condition per rail
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;

	// Word decode shared by read and write paths
	function automatic logic is_buck(input logic [7:0] a, input int unsigned i);
		is_buck = (a == rail_seq_pkg::BUCK_CTRL_BASE + 8'(4 * i));
	endfunction

	// Zero-wait slave; every access finishes in its access cycle
	assign pready_o  = 1'b1;
	assign wr_en     = psel_i & penable_i & pwrite_i;
	assign rd_en     = psel_i & penable_i & ~pwrite_i;
	assign addr_ok   = (paddr_i < 8'h18) ? (paddr_i[1:0] == 2'b00) :
		(paddr_i[1:0] == 2'b00) && (paddr_i >= 8'h20) && (paddr_i <= 8'h38);
	assign pslverr_o = psel_i & penable_i & ~addr_ok;

	// Step-down control words; range bit is never stored
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			for (int i = 0; i < 6; i++)
				ctrl_q[i] <= {2'b00, rail_seq_pkg::VID_DEFAULT[i*7 +: 7]};
		end
		else if (wr_en)
		begin
			for (int i = 0; i < 6; i++)
				if (is_buck(paddr_i, i))
					ctrl_q[i] <= {1'b0, pwdata_i[rail_seq_pkg::MODE_BIT],
						pwdata_i[rail_seq_pkg::VID_LSB +: rail_seq_pkg::VID_W]};
		end
	end

	// Discharge, shared, aux and output-level registers
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			disch_q[0] <= rail_seq_pkg::DISCH_RESET;
			disch_q[1] <= rail_seq_pkg::DISCH_RESET;
			disch_q[2] <= rail_seq_pkg::DISCH_RESET;
			shared_q   <= 4'h2;
			aux_q      <= 2'b00;
			gpo_q      <= 2'b00;
		end
		else if (wr_en)
		begin
			case (paddr_i)
				rail_seq_pkg::DISCH_CNT1:  disch_q[0] <= pwdata_i;
				rail_seq_pkg::DISCH_CNT2:  disch_q[1] <= pwdata_i;
				rail_seq_pkg::DISCH_CNT3:  disch_q[2] <= pwdata_i;
				rail_seq_pkg::SHARED_CTRL: shared_q   <= pwdata_i[3:0];
				rail_seq_pkg::AUX_CTRL:    aux_q      <= pwdata_i[1:0];
				rail_seq_pkg::GPO_CTRL:    gpo_q      <= pwdata_i[1:0];
				default:                   ;
			endcase
		end
	end

	// Read mux; range bit shows factory value, status shows live state
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			prdata_o <= 32'h00000000;
		else if (psel_i && !penable_i && !pwrite_i)
		begin
			prdata_o <= 32'h00000000;
			for (int i = 0; i < 6; i++)
				if (is_buck(paddr_i, i))
					prdata_o <= {23'h000000, rail_seq_pkg::FINE_RANGE[i], ctrl_q[i][7:0]};
			case (paddr_i)
				rail_seq_pkg::DISCH_CNT1:  prdata_o <= disch_q[0];
				rail_seq_pkg::DISCH_CNT2:  prdata_o <= disch_q[1];
				rail_seq_pkg::DISCH_CNT3:  prdata_o <= disch_q[2];
				rail_seq_pkg::SHARED_CTRL: prdata_o <= {28'h0000000, shared_q};
				rail_seq_pkg::AUX_CTRL:    prdata_o <= {30'h00000000, aux_q};
				rail_seq_pkg::GPO_CTRL:    prdata_o <= {30'h00000000, gpo_q};
				rail_seq_pkg::RAIL_STATUS: prdata_o <= {16'h0000, buck_pg_i,
					pg_two_q, pg_one_q, en_q, 2'b00};
				default:                   ;
			endcase
		end
	end

	// Enable conditions: pins gate the first group, power-good chains the rest
	always_comb
	begin
		cond[0] = enable_pin_one_i;
		cond[1] = enable_pin_one_i & buck_pg_i[0];
		cond[2] = enable_pin_two_i & pg_one_q;
		cond[3] = enable_pin_two_i & pg_one_q & buck_pg_i[2];
		cond[4] = enable_pin_two_i & pg_one_q & buck_pg_i[3];
		cond[5] = enable_pin_two_i & pg_one_q & buck_pg_i[4];
	end

	// Power-down chain: first rail of each group drops at once, later rails
	// wait until the rail above is off and its delay has elapsed
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			en_q <= 6'h00;
			for (int i = 0; i < 6; i++)
				cnt_q[i] <= 32'h00000000;
		end
		else
		begin
			for (int i = 0; i < 6; i++)
			begin
				if (cond[i])
				begin
					en_q[i]  <= 1'b1;
					cnt_q[i] <= 32'h00000000;
				end
				else if (en_q[i])
				begin
					// Top of each group has no upstream rail; the rest wait
					if (i == 0 || i == 2 || !en_q[i-1])
					begin
						if (cnt_q[i] >= PD_DELAY_CYCLES - 1 || i == 0 || i == 2)
							en_q[i] <= 1'b0;
						else
							cnt_q[i] <= cnt_q[i] + 32'h00000001;
					end
				end
			end
		end
	end

	// Group power-good levels drop on the next clock edge after pins fall
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pg_one_q <= 1'b0;
			pg_two_q <= 1'b0;
		end
		else
		begin
			pg_one_q <= enable_pin_one_i & buck_pg_i[0] & buck_pg_i[1];
			pg_two_q <= enable_pin_two_i & enable_pin_one_i & pg_one_q &
				(&buck_pg_i[5:2]);
		end
	end

	// Rail-side outputs
	always_comb
	begin
		for (int i = 0; i < 6; i++)
		begin
			buck_pwm_o[i]            = ctrl_q[i][rail_seq_pkg::MODE_BIT];
			buck_vid_o[i*7 +: 7]     = ctrl_q[i][6:0];
			disch_strength_o[i*2 +: 2] = disch_q[i/2][(i%2)*4 +: 2];
		end
	end
	assign buck_en_o            = en_q;
	assign buck_fine_range_o    = rail_seq_pkg::FINE_RANGE;
	assign buck_disch_on_o      = ~en_q;
	assign vtt_en_o             = en_q[5];
	assign switch_a_first_en_o  = enable_pin_four_i;
	assign switch_b_first_en_o  = enable_pin_four_i;
	assign switch_b_second_en_o = enable_pin_five_i;
	assign first_aux_ldo_en_o   = shared_q[rail_seq_pkg::SH_EN_BIT];
	assign second_aux_ldo_en_o  = aux_q[0];
	assign third_aux_ldo_en_o   = aux_q[1];

	// Open drain: pull low while not good or level bit clear, release when good or set
	assign pg_out_one_o    = 1'b0;
	assign pg_out_one_oe_o = ~pg_one_q;
	assign pg_out_two_o    = 1'b0;
	assign pg_out_two_oe_o = ~pg_two_q;
	assign gpo_three_o     = 1'b0;
	assign gpo_three_oe_o  = ~gpo_q[0];
	assign gpo_four_o      = 1'b0;
	assign gpo_four_oe_o   = ~gpo_q[1];
endmodule
`default_nettype wire

// ==== design/rail_seq_pkg.sv ====
// Functional notes
// - Enabled rail drops its discharge resistor automatically
// - Discharge strength per rail set by registers
// - Enables come from pins and power-good mix
// - Simultaneous pin falls run both sequences together
// - Early first pin fall drops both PG outputs
// - Next rail delay starts when previous turns off
// - Pin four/five drive switches; aux LDOs software only
// - Shared register enable bit drives first aux LDO only
// - Per step-down mode bit: forced PWM or auto
// - Voltage target writable anytime; starts at default
// - Step range factory fixed, writes cannot change
// - Seven-bit target code, zero means off
package rail_seq_pkg;
	localparam int unsigned NUM_BUCK      = 6;
	localparam int unsigned CLK_HZ        = 100000000;
	localparam int unsigned PD_DELAY_MS   = 4;
	localparam int unsigned PD_DELAY_CYC  = PD_DELAY_MS * (CLK_HZ / 1000);
	// APB register byte offsets
	localparam logic [7:0] BUCK_CTRL_BASE = 8'h00; // six words 0x00..0x14
	localparam logic [7:0] DISCH_CNT1     = 8'h20;
	localparam logic [7:0] DISCH_CNT2     = 8'h24;
	localparam logic [7:0] DISCH_CNT3     = 8'h28;
	localparam logic [7:0] SHARED_CTRL    = 8'h2c;
	localparam logic [7:0] AUX_CTRL       = 8'h30;
	localparam logic [7:0] GPO_CTRL       = 8'h34;
	localparam logic [7:0] RAIL_STATUS    = 8'h38;
	// Step-down control fields
	localparam int unsigned VID_LSB       = 0;
	localparam int unsigned VID_W         = 7;
	localparam int unsigned MODE_BIT      = 7;
	localparam int unsigned RANGE_BIT     = 8;
	// Shared register fields
	localparam int unsigned SH_EN_BIT     = 0;
	localparam int unsigned SH_DIS_LSB    = 1;
	// Factory defaults: codes for 1.0,1.8,1.2,2.5,3.3,1.5 V
	localparam logic [NUM_BUCK*7-1:0] VID_DEFAULT =
		{7'h2d, 7'h5d, 7'h45, 7'h15, 7'h39, 7'h3c};
	localparam logic [NUM_BUCK-1:0] FINE_RANGE = 6'h01; // Only first rail fine
	localparam logic [31:0] DISCH_RESET   = 32'h00000055;
endpackage

// ==== dv/rail_enable_sequencer_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module rail_enable_sequencer_bench;
	logic clk_i = 0, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata_o, q;
	logic pready_o, pslverr_o, err, one, two, four = 0, five = 0;
	logic want_one = 0, want_two = 0, early = 0, s_a, s_b1, s_b2, l1, l2, l3, oe1, oe2, g3oe;
	logic [5:0] pg, en, pwm, fine, dsc;
	logic [41:0] voltage_target_code;
	logic [11:0] dstr;
	int num_errors = 0, cmp_count = 0;
	always #5 clk_i = ~clk_i; // 100 MHz
	rail_enable_sequencer #(.PD_DELAY_CYCLES(20)) i_dut (.clk_i, .reset_n_i, .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o,
		.pready_o, .pslverr_o, .enable_pin_one_i(one), .enable_pin_two_i(two),
		.enable_pin_four_i(four), .enable_pin_five_i(five), .buck_pg_i(pg), .buck_en_o(en),
		.buck_pwm_o(pwm), .buck_vid_o(voltage_target_code), .buck_fine_range_o(fine), .buck_disch_on_o(dsc),
		.disch_strength_o(dstr), .vtt_en_o(), .switch_a_first_en_o(s_a),
		.switch_b_first_en_o(s_b1), .switch_b_second_en_o(s_b2), .first_aux_ldo_en_o(l1),
		.second_aux_ldo_en_o(l2), .third_aux_ldo_en_o(l3), .pg_out_one_o(),
		.pg_out_one_oe_o(oe1), .pg_out_two_o(), .pg_out_two_oe_o(oe2), .gpo_three_o(),
		.gpo_three_oe_o(g3oe), .gpo_four_o(), .gpo_four_oe_o());
	rail_host_model i_host (.clk_i, .reset_n_i, .want_one_i(want_one), .want_two_i(want_two),
		.early_i(early), .buck_en_i(en), .pin_one_o(one), .pin_two_o(two), .pg_o(pg));
	// One APB transfer; held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		q = prdata_o;
		err = pslverr_o;
		{psel, penable} <= 2'b00;
		@(posedge clk_i); // Let the write land before callers look
	endtask
	// Bounded wait for a rail pattern
	task wait_en(input logic [5:0] v);
		int n;
		n = 0;
		while (en !== v && n < 3000) begin @(posedge clk_i); n++; end
		`CHK(en, v)
	endtask
	task t_regs;
		apb(0, rail_seq_pkg::DISCH_CNT1, 0); `CHK(q, rail_seq_pkg::DISCH_RESET)
		apb(1, rail_seq_pkg::DISCH_CNT1, 32'h2); `CHK(dstr[1:0], 2'h2)
		apb(0, 8'h00, 0); `CHK(q[8:0], 9'h13c)
		apb(1, 8'h00, 32'hff); `CHK({fine[0], pwm[0], voltage_target_code[6:0]}, 9'h1ff)
		apb(1, 8'h00, 32'h0); `CHK({pwm[0], voltage_target_code[6:0]}, 8'h00)
		apb(1, 8'h04, 32'h100); `CHK(fine[1], 1'b0)
		apb(0, 8'h3c, 0); `CHK({err, q}, {1'b1, 32'h0})
	endtask
	task t_pins;
		for (int i = 0; i < 4; i++) begin
			four <= i[0]; five <= i[1]; repeat (2) @(posedge clk_i);
			`CHK({s_a, s_b1, s_b2}, {i[0], i[0], i[1]})
		end
		apb(1, rail_seq_pkg::AUX_CTRL, 32'h3); `CHK({l3, l2}, 2'b11)
		apb(1, rail_seq_pkg::SHARED_CTRL, 32'h1); `CHK(l1, 1'b1)
		apb(1, rail_seq_pkg::GPO_CTRL, 32'h1); `CHK(g3oe, 1'b0)
	endtask
	task t_both;
		want_one <= 1; want_two <= 1; wait_en(6'h3f);
		repeat (4) @(posedge clk_i); `CHK({oe1, oe2, dsc}, 8'h00)
		want_one <= 0; want_two <= 0; wait_en(6'h00); `CHK({oe1, oe2}, 2'b11)
	endtask
	task t_early;
		want_one <= 1; want_two <= 1; wait_en(6'h3f);
		early <= 1; want_one <= 0; repeat (3) @(posedge clk_i);
		`CHK({oe1, oe2}, 2'b11)
		wait_en(6'h00); want_two <= 0; early <= 0;
	endtask
	task complete_run;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin repeat (20000) @(posedge clk_i); num_errors++; complete_run(); end
	initial begin
		repeat (16) @(posedge clk_i);
		reset_n_i <= 1;
		t_regs(); t_pins(); t_both(); t_early();
		complete_run();
	end
endmodule
`default_nettype wire

// ==== dv/rail_enable_sequencer_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module rail_props #(
	parameter int unsigned PD_DELAY_CYCLES = 20
) (
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        enable_pin_one_i,
	input wire logic        enable_pin_two_i,
	input wire logic        enable_pin_four_i,
	input wire logic        enable_pin_five_i,
	input wire logic [5:0]  buck_en_o,
	input wire logic [5:0]  buck_pwm_o,
	input wire logic [41:0] buck_vid_o,
	input wire logic [5:0]  buck_fine_range_o,
	input wire logic [5:0]  buck_disch_on_o,
	input wire logic        switch_a_first_en_o,
	input wire logic        switch_b_first_en_o,
	input wire logic        switch_b_second_en_o,
	input wire logic        pg_out_one_oe_o,
	input wire logic        pg_out_two_oe_o
);
	localparam int MIN_OFF = PD_DELAY_CYCLES - 2; // Slack for pipeline stages
	logic [31:0] off_q; // Cycles the third rail has been off
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// Off counter for the third rail, clears while it is on
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			off_q <= '0;
		else
			off_q <= buck_en_o[2] ? '0 : off_q + 32'h1;
	end
	wire wr_rail1 = psel_i && penable_i && pwrite_i && paddr_i == 8'h04;
	disch_follow_a: assert property (buck_disch_on_o == ~buck_en_o)
		else $error("discharge not opposite to enable");
	enable_src_a: assert property (buck_en_o[0] |->
		$past(enable_pin_one_i) || $past(enable_pin_one_i, 2))
		else $error("first rail on without its pin");
	both_fall_a: assert property ($fell(enable_pin_one_i) && $fell(enable_pin_two_i)
		|-> ##[1:2] (!buck_en_o[0] && !buck_en_o[2])) else $error("sequences not parallel");
	pg_drop_a: assert property ($fell(enable_pin_one_i)
		|-> ##[1:2] (pg_out_one_oe_o && pg_out_two_oe_o)) else $error("good outputs held");
	chain_delay_a: assert property ($fell(buck_en_o[3]) |-> off_q >= MIN_OFF)
		else $error("chained rail dropped early");
	switch_pins_a: assert property ({switch_a_first_en_o, switch_b_first_en_o,
		switch_b_second_en_o} == {enable_pin_four_i, enable_pin_four_i, enable_pin_five_i})
		else $error("switch enables off their pins");
	mode_write_a: assert property (wr_rail1 |=> buck_pwm_o[1] == $past(pwdata_i[7]))
		else $error("mode bit not taken");
	target_write_a: assert property (wr_rail1 |=> buck_vid_o[13:7] == $past(pwdata_i[6:0]))
		else $error("target code not taken");
	range_fixed_a: assert property (buck_fine_range_o == rail_seq_pkg::FINE_RANGE)
		else $error("step range changed");
	cover property ($fell(buck_en_o[3]));
	cover property ($fell(enable_pin_one_i) && enable_pin_two_i);
	cover property (wr_rail1);
endmodule
bind rail_enable_sequencer rail_props #(.PD_DELAY_CYCLES(PD_DELAY_CYCLES)) i_props (.*);
`default_nettype wire

// ==== dv/rail_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Host side: drives the two enable pins and loops rail enables back as good
module rail_host_model (
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       want_one_i,
	input  wire logic       want_two_i,
	input  wire logic       early_i,
	input  wire logic [5:0] buck_en_i,
	output logic            pin_one_o,
	output logic            pin_two_o,
	output logic      [5:0] pg_o
);
	// Pin one never falls ahead of pin two unless early_i asks for it
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pin_one_o <= 1'b0;
			pin_two_o <= 1'b0;
			pg_o      <= 6'h00;
		end
		else
		begin
			pin_two_o <= want_two_i;
			pin_one_o <= want_one_i | (want_two_i & !early_i);
			pg_o      <= buck_en_i; // Good one cycle after enable
		end
	end
endmodule
`default_nettype wire
